// ### hw/dcg_pkg.sv
// Constants and types shared by the dual CAN glue block
// =====================================================================
package dcg_pkg;
  // ===================================================================
  // Address map
  localparam logic [23:0] SECOND_CAN_CONTROLLER_BASE      = 24'h00EE00;
  localparam logic [23:0] SECOND_CAN_CONTROLLER_LAST      = 24'h00EEFF;
  localparam logic [23:0] FIRST_CAN_CONTROLLER_BASE      = 24'h00EF00;
  localparam logic [23:0] FIRST_CAN_CONTROLLER_LAST      = 24'h00EFFF;
  localparam logic [23:0] MISC_ADDR      = 24'h00EB50;
  // ===================================================================
  // Peripheral enable register field positions
  localparam int          PEN_FIRST_CAN_CONTROLLER_POS   = 0;
  localparam int          PEN_SECOND_CAN_CONTROLLER_POS   = 1;
  localparam int          PEN_MISC_POS   = 2;
  localparam logic [2:0]  PEN_RESET      = 3'h1;
  // Misc control register field positions and reset value
  localparam int          MISC_PAR_POS   = 0;
  localparam int          MISC_HALF_POS  = 1;
  localparam logic [1:0]  MISC_RESET     = 2'h2;
  // ===================================================================
  // Timing
  localparam int          WAIT_STATES    = 2;
  localparam logic [1:0]  WAIT_LAST      = 2'(WAIT_STATES);
  localparam int          SEG_LINES_CAN  = 4;
  localparam logic [7:0]  SEG_MASK_CAN   = 8'h0F;
  localparam logic [7:0]  SEG_MASK_ALL   = 8'hFF;
  // Error flag and resync figures; the controllers own bit timing,
  // so the glue only carries these for them
  localparam int          ERR_FLAG_BITS  = 6;
  localparam int          RESYNC_MAX     = 10;
  localparam int          POST_FLAG_BIT  = 13;
  localparam logic [2:0]  SJW_MIN        = 3'h1;
  localparam logic [2:0]  SJW_MAX        = 3'h4;
  // Access state machine
  typedef enum logic [1:0] {DCG_IDLE, DCG_WAIT, DCG_DONE} dcg_state_t;
endpackage : dcg_pkg

// ### hw/dcg_clk_div.sv
// CAN clock enable generator: CPU rate or half rate
`timescale 1ns/10ps
`default_nettype none
module dcg_clk_div (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic halve,
  // Enable pulse out
  output logic      can_clk_en
);
  logic tog_q;
  logic tog_d;

  // Divider toggles every cycle; halve gates the enable to every other
  always_comb begin
    tog_d      = ~tog_q;
    can_clk_en = halve ? tog_q : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tog_q <= 1'b0;
    end else begin
      tog_q <= tog_d;
    end
  end
endmodule : dcg_clk_div
`default_nettype wire

// ### hw/dcg_pin_mux.sv
// Port 4 pin routing for two CAN controllers
`timescale 1ns/10ps
`default_nettype none
module dcg_pin_mux (
  // Routing controls
  input  wire logic       par_active,
  input  wire logic       first_can_controller_on,
  input  wire logic       second_can_controller_on,
  input  wire logic [3:0] port_open_drain_control,
  // Controller transmit lines
  input  wire logic       first_can_transmit_out,
  input  wire logic       second_can_transmit_out,
  // General I/O for lines four..seven
  input  wire logic [3:0] gpio_out,
  input  wire logic [3:0] gpio_oe,
  // Pin receive levels
  input  wire logic [3:0] pin_in,
  // Pin drive
  output logic      [3:0] pin_out,
  output logic      [3:0] pin_oe,
  // Receive lines to controllers
  output logic            first_can_controller_rx,
  output logic            second_can_controller_rx,
  // Freed line flags
  output logic      [3:0] freed
);
  logic tx_wired;

  // Index 0..3 stands for port four lines four..seven
  always_comb begin
    tx_wired = first_can_transmit_out & second_can_transmit_out;
    pin_out  = gpio_out;
    pin_oe   = gpio_oe;
    freed    = 4'hF;
    first_can_controller_rx  = 1'b1;
    second_can_controller_rx  = 1'b1;
    if (first_can_controller_on) begin
      freed[1] = 1'b0;
      freed[2] = 1'b0;
      first_can_controller_rx  = pin_in[1];
      // Line six carries the wired AND in parallel mode
      pin_out[2] = par_active ? tx_wired : first_can_transmit_out;
      // Open drain: drive only the dominant low
      pin_oe[2]  = port_open_drain_control[2] ? ~pin_out[2] : 1'b1;
    end
    if (second_can_controller_on && par_active) begin
      second_can_controller_rx = pin_in[1];
    end else if (second_can_controller_on) begin
      freed[0]   = 1'b0;
      freed[3]   = 1'b0;
      second_can_controller_rx    = pin_in[0];
      pin_out[3] = second_can_transmit_out;
      pin_oe[3]  = port_open_drain_control[3] ? ~pin_out[3] : 1'b1;
    end
  end
endmodule : dcg_pin_mux
`default_nettype wire

// ### hw/dcg_top.sv
// Dual CAN glue: window decode, enables, wait states, pins, clock
`timescale 1ns/10ps
`default_nettype none
module dcg_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Global enable from the system config register
  input  wire logic        onchip_periph_global_enable,
  // Peripheral enable register write port
  input  wire logic        pen_we,
  input  wire logic [2:0]  pen_wdata,
  // Peripheral bus request
  input  wire logic        bus_req,
  input  wire logic        bus_we,
  input  wire logic [23:0] bus_addr,
  input  wire logic [1:0]  bus_be,
  input  wire logic [15:0] bus_wdata,
  // Peripheral bus answer
  output logic             bus_ready,
  output logic [15:0]      bus_rdata,
  output logic             bus_hit,
  // Controller access strobes
  output logic             first_can_controller_sel,
  output logic             second_can_controller_sel,
  output logic             can_we,
  output logic [1:0]       can_be,
  output logic [7:0]       can_addr,
  output logic [15:0]      can_wdata,
  input  wire logic [15:0] first_can_controller_rdata,
  input  wire logic [15:0] second_can_controller_rdata,
  // Controller enables and clock enable
  output logic             first_can_controller_active,
  output logic             second_can_controller_active,
  output logic             can_clk_en,
  // Controller transmit and receive
  input  wire logic        first_can_transmit_out,
  input  wire logic        second_can_transmit_out,
  output logic             first_can_controller_rx,
  output logic             second_can_controller_rx,
  // Port four lines four..seven
  input  wire logic [3:0]  port_open_drain_control,
  input  wire logic [3:0]  gpio_out,
  input  wire logic [3:0]  gpio_oe,
  input  wire logic [3:0]  pin_in,
  output logic [3:0]       pin_out,
  output logic [3:0]       pin_oe,
  output logic [3:0]       pin_freed,
  output logic [3:0]       pin_addr_allowed,
  // Segment address lines allowed on port four
  output logic [7:0]       seg_line_mask
);
  // ===================================================================
  // Register state
  logic [2:0]        pen_q;
  logic [2:0]        pen_d;
  logic [1:0]        misc_q;
  logic [1:0]        misc_d;
  dcg_pkg::dcg_state_t st_q;
  dcg_pkg::dcg_state_t st_d;
  logic [1:0]        wcnt_q;
  logic [1:0]        wcnt_d;
  logic [15:0]       rdata_q;
  logic [15:0]       rdata_d;
  logic              hit_q;
  logic              hit_d;
  logic [1:0]        tgt_q;
  logic [1:0]        tgt_d;

  // Decode signals
  logic in_first_can_controller;
  logic in_second_can_controller;
  logic in_misc;
  logic misc_ok;
  logic par_active;

  // Inclusive window compare, used for both controller windows
  function automatic logic in_win(input logic [23:0] a,
                                  input logic [23:0] lo,
                                  input logic [23:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction : in_win

  // ===================================================================
  // Enables and decode
  always_comb begin
    first_can_controller_active = onchip_periph_global_enable
                  & pen_q[dcg_pkg::PEN_FIRST_CAN_CONTROLLER_POS];
    second_can_controller_active = onchip_periph_global_enable
                  & pen_q[dcg_pkg::PEN_SECOND_CAN_CONTROLLER_POS];
    misc_ok     = onchip_periph_global_enable
                  & pen_q[dcg_pkg::PEN_MISC_POS];
    in_second_can_controller = in_win(bus_addr, dcg_pkg::SECOND_CAN_CONTROLLER_BASE, dcg_pkg::SECOND_CAN_CONTROLLER_LAST);
    in_first_can_controller = in_win(bus_addr, dcg_pkg::FIRST_CAN_CONTROLLER_BASE, dcg_pkg::FIRST_CAN_CONTROLLER_LAST);
    in_misc = (bus_addr == dcg_pkg::MISC_ADDR);
    // Parallel mode only counts with both controllers running
    par_active = misc_q[dcg_pkg::MISC_PAR_POS]
                 & first_can_controller_active & second_can_controller_active;
    // Only four segment lines once any CAN is in use
    seg_line_mask = (first_can_controller_active | second_can_controller_active)
                    ? dcg_pkg::SEG_MASK_CAN
                    : dcg_pkg::SEG_MASK_ALL;
  end

  // ===================================================================
  // Peripheral enable register, written by software
  always_comb begin
    pen_d = pen_q;
    if (pen_we) begin
      pen_d = pen_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pen_q <= dcg_pkg::PEN_RESET;
    end else begin
      pen_q <= pen_d;
    end
  end

  // ===================================================================
  // Access sequencer: two wait states, then one ready cycle
  always_comb begin
    st_d    = st_q;
    wcnt_d  = wcnt_q;
    rdata_d = rdata_q;
    hit_d   = hit_q;
    tgt_d   = tgt_q;
    misc_d  = misc_q;
    case (st_q)
      dcg_pkg::DCG_IDLE: begin
        if (bus_req) begin
          // Disabled windows are never selected, but the access still runs its wait states
          tgt_d  = {in_second_can_controller & second_can_controller_active, in_first_can_controller & first_can_controller_active};
          hit_d  = (in_first_can_controller & first_can_controller_active) | (in_second_can_controller & second_can_controller_active)
                   | (in_misc & misc_ok);
          wcnt_d = 2'h1;
          st_d   = dcg_pkg::DCG_WAIT;
          if (in_misc && misc_ok && bus_we && bus_be[0]) begin
            misc_d = bus_wdata[1:0];
          end
          rdata_d = 16'h0000;
          if (in_misc && misc_ok) begin
            rdata_d = {14'h0000, misc_q};
          end
        end
      end
      dcg_pkg::DCG_WAIT: begin
        if (wcnt_q == dcg_pkg::WAIT_LAST) begin
          st_d = dcg_pkg::DCG_DONE;
          if (tgt_q[1]) begin
            rdata_d = second_can_controller_rdata;
          end else if (tgt_q[0]) begin
            rdata_d = first_can_controller_rdata;
          end
        end else begin
          wcnt_d = 2'(wcnt_q + 2'h1);
        end
      end
      dcg_pkg::DCG_DONE: begin
        st_d  = dcg_pkg::DCG_IDLE;
        tgt_d = 2'h0;
      end
      default: begin
        st_d = dcg_pkg::DCG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q    <= dcg_pkg::DCG_IDLE;
      wcnt_q  <= 2'h0;
      rdata_q <= 16'h0000;
      hit_q   <= 1'b0;
      tgt_q   <= 2'h0;
      misc_q  <= dcg_pkg::MISC_RESET;
    end else begin
      st_q    <= st_d;
      wcnt_q  <= wcnt_d;
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
      tgt_q   <= tgt_d;
      misc_q  <= misc_d;
    end
  end

  // ===================================================================
  // Controller strobes: held through the wait states
  always_comb begin
    first_can_controller_sel  = (st_q == dcg_pkg::DCG_WAIT) & tgt_q[0];
    second_can_controller_sel  = (st_q == dcg_pkg::DCG_WAIT) & tgt_q[1];
    can_we    = bus_we;
    can_be    = bus_be;
    can_addr  = bus_addr[7:0];
    can_wdata = bus_wdata;
    bus_ready = (st_q == dcg_pkg::DCG_DONE);
    bus_rdata = rdata_q;
    bus_hit   = hit_q;
    // Freed lines may serve as I/O or I2C but never as address lines
    pin_addr_allowed = 4'h0;
  end

  // ===================================================================
  // Shared CAN clock enable
  dcg_clk_div u_div (
    .clk        (clk),
    .rst_n      (rst_n),
    .halve      (misc_q[dcg_pkg::MISC_HALF_POS]),
    .can_clk_en (can_clk_en)
  );

  // Pin routing; freed lines fall back to general I/O
  dcg_pin_mux u_mux (
    .par_active              (par_active),
    .first_can_controller_on                 (first_can_controller_active),
    .second_can_controller_on                 (second_can_controller_active),
    .port_open_drain_control (port_open_drain_control),
    .first_can_transmit_out  (first_can_transmit_out),
    .second_can_transmit_out (second_can_transmit_out),
    .gpio_out                (gpio_out),
    .gpio_oe                 (gpio_oe),
    .pin_in                  (pin_in),
    .pin_out                 (pin_out),
    .pin_oe                  (pin_oe),
    .first_can_controller_rx                 (first_can_controller_rx),
    .second_can_controller_rx                 (second_can_controller_rx),
    .freed                   (pin_freed)
  );
endmodule : dcg_top
`default_nettype wire

// ### tb/dcg_monitor.sv
// Port-level checker for the dual CAN glue top module
`timescale 1ns/10ps
`default_nettype none
// ====================================================================
// Checker
module dcg_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus side
  input wire logic [23:0] bus_addr,
  input wire logic        bus_ready,
  input wire logic        bus_hit,
  input wire logic        first_can_controller_sel,
  input wire logic        second_can_controller_sel,
  // Enables and pins
  input wire logic        first_can_controller_active,
  input wire logic        second_can_controller_active,
  input wire logic        second_can_controller_rx,
  input wire logic        second_can_transmit_out,
  input wire logic [3:0]  port_open_drain_control,
  input wire logic [3:0]  gpio_out,
  input wire logic [3:0]  gpio_oe,
  input wire logic [3:0]  pin_in,
  input wire logic [3:0]  pin_out,
  input wire logic [3:0]  pin_oe,
  input wire logic [3:0]  pin_freed,
  input wire logic [3:0]  pin_addr_allowed,
  input wire logic [7:0]  seg_line_mask
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Select may only fall inside the second window
  win_decode_a: assert property (
    second_can_controller_sel |-> bus_addr[23:8] == 16'h00EE)
    else $error("second select outside its window");
  sel_gate_a: assert property (second_can_controller_sel |-> second_can_controller_active)
    else $error("second select while disabled");
  // Two wait cycles, then a single ready
  wait_two_a: assert property (
    $rose(first_can_controller_sel | second_can_controller_sel) |-> ##1 (first_can_controller_sel | second_can_controller_sel)
    ##1 (!(first_can_controller_sel | second_can_controller_sel) && bus_ready))
    else $error("access length wrong");
  ready_pulse_a: assert property (bus_ready |=> !bus_ready)
    else $error("ready longer than one cycle");
  seg_mask_a: assert property (
    seg_line_mask == ((first_can_controller_active | second_can_controller_active) ? 8'h0F : 8'hFF))
    else $error("segment mask wrong");
  addr_free_a: assert property (pin_addr_allowed == 4'h0)
    else $error("port line offered as address");
  // Without the first controller, the second keeps its own pins
  own_rx_a: assert property (
    (second_can_controller_active && !first_can_controller_active) |-> second_can_controller_rx == pin_in[0])
    else $error("second receive not on its own line");
  od_release_a: assert property (
    (second_can_controller_active && !first_can_controller_active && port_open_drain_control[3]
     && second_can_transmit_out) |-> !pin_oe[3])
    else $error("open drain line driven high");
  gpio_back_a: assert property (
    pin_freed[3] |-> pin_oe[3] == gpio_oe[3]
    && (!gpio_oe[3] || pin_out[3] == gpio_out[3]))
    else $error("freed line not general purpose");
  cover property (second_can_controller_sel);
  cover property (bus_ready && !bus_hit);
  cover property (pin_freed[3]);
endmodule : dcg_monitor
bind dcg_top dcg_monitor u_mon (.clk, .rst_n, .bus_addr, .bus_ready,
  .bus_hit, .first_can_controller_sel, .second_can_controller_sel, .first_can_controller_active, .second_can_controller_active, .second_can_controller_rx,
  .second_can_transmit_out, .port_open_drain_control, .gpio_out, .gpio_oe,
  .pin_in, .pin_out, .pin_oe, .pin_freed, .pin_addr_allowed, .seg_line_mask);
`default_nettype wire

// ### tb/dcg_can_model.sv
// Model of the two controllers' registers and a shared transceiver
`timescale 1ns/10ps
`default_nettype none
// ====================================================================
// Far side
module dcg_can_model (
  // Clock
  input wire logic        clk,
  // Controller access
  input wire logic        first_can_controller_sel,
  input wire logic        second_can_controller_sel,
  input wire logic        can_we,
  input wire logic [1:0]  can_be,
  input wire logic [7:0]  can_addr,
  input wire logic [15:0] can_wdata,
  output logic     [15:0] first_can_controller_rdata,
  output logic     [15:0] second_can_controller_rdata,
  // Pins and a remote node pulling dominant
  input wire logic [3:0]  pin_out,
  input wire logic [3:0]  pin_oe,
  input wire logic        remote_dom,
  output logic     [3:0]  pin_in
);
  logic [15:0] mem1 [256];
  logic [15:0] mem2 [256];
  logic [3:0]  lvl;
  logic        bus;
  // Byte-lane writes; an unselected controller shows garbage
  always @(posedge clk) begin
    if (first_can_controller_sel && can_we && can_be[0]) begin
      mem1[can_addr][7:0] <= can_wdata[7:0];
    end
    if (first_can_controller_sel && can_we && can_be[1]) begin
      mem1[can_addr][15:8] <= can_wdata[15:8];
    end
    if (second_can_controller_sel && can_we && can_be[0]) begin
      mem2[can_addr][7:0] <= can_wdata[7:0];
    end
    if (second_can_controller_sel && can_we && can_be[1]) begin
      mem2[can_addr][15:8] <= can_wdata[15:8];
    end
  end
  assign first_can_controller_rdata = first_can_controller_sel ? mem1[can_addr] : ~mem1[can_addr];
  assign second_can_controller_rdata = second_can_controller_sel ? mem2[can_addr] : ~mem2[can_addr];
  // Remote node timing is taken to sit inside the jump width budget
  // Pull-ups make released lines recessive; wired-AND onto one bus
  assign lvl = (pin_out | ~pin_oe);
  assign bus = lvl[2] & lvl[3] & ~remote_dom;
  assign pin_in = {lvl[3], lvl[2], bus, bus};
endmodule : dcg_can_model
`default_nettype wire

// ### tb/test_dual_can_integration_glue.sv
// Self-checking bench for the dual CAN glue block
`timescale 1ns/10ps
`default_nettype none
// ====================================================================
// Bench
module test_dual_can_integration_glue;
  logic        clk, rst_n, glob, pen_we, bus_req, bus_we, tx1, tx2, rdom;
  logic        ready, hit, c1s, c2s, cwe, c1a, c2a, cen, rx1, rx2, h;
  logic [2:0]  pen_wdata;
  logic [23:0] bus_addr;
  logic [1:0]  bus_be, cbe;
  logic [15:0] bus_wdata, bus_rdata, c1r, c2r, cwd, rd;
  logic [3:0]  od, g_out, g_oe, p_in, p_out, p_oe, freed, aok;
  logic [7:0]  caddr, seg;
  int          err_count, n_checks, cyc;
  dcg_top uut (.clk(clk), .rst_n(rst_n), .onchip_periph_global_enable(glob),
    .pen_we(pen_we), .pen_wdata(pen_wdata), .bus_req(bus_req),
    .bus_we(bus_we), .bus_addr(bus_addr), .bus_be(bus_be),
    .bus_wdata(bus_wdata), .bus_ready(ready), .bus_rdata(bus_rdata),
    .bus_hit(hit), .first_can_controller_sel(c1s), .second_can_controller_sel(c2s), .can_we(cwe),
    .can_be(cbe), .can_addr(caddr), .can_wdata(cwd), .first_can_controller_rdata(c1r),
    .second_can_controller_rdata(c2r), .first_can_controller_active(c1a), .second_can_controller_active(c2a),
    .can_clk_en(cen), .first_can_transmit_out(tx1),
    .second_can_transmit_out(tx2), .first_can_controller_rx(rx1), .second_can_controller_rx(rx2),
    .port_open_drain_control(od), .gpio_out(g_out), .gpio_oe(g_oe),
    .pin_in(p_in), .pin_out(p_out), .pin_oe(p_oe), .pin_freed(freed),
    .pin_addr_allowed(aok), .seg_line_mask(seg));
  dcg_can_model u_node (.clk(clk), .first_can_controller_sel(c1s), .second_can_controller_sel(c2s),
    .can_we(cwe), .can_be(cbe), .can_addr(caddr), .can_wdata(cwd),
    .first_can_controller_rdata(c1r), .second_can_controller_rdata(c2r), .pin_out(p_out), .pin_oe(p_oe),
    .remote_dom(rdom), .pin_in(p_in));
  always #20 clk = ~clk;
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      end_of_test();
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One bus access; qualifiers stay put until ready is seen
  task automatic acc(input logic we, input logic [23:0] a,
                     input logic [1:0] be, input logic [15:0] d);
    int n;
    @(negedge clk);
    bus_req = 1'h1;
    bus_we = we;
    bus_addr = a;
    bus_be = be;
    bus_wdata = d;
    n = 0;
    @(negedge clk);
    while (ready !== 1'h1 && n < 9) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n), 16'(dcg_pkg::WAIT_STATES));
    // Request stands through the edge that samples ready, then drops
    @(negedge clk);
    rd = bus_rdata;
    h = hit;
    bus_req = 1'h0;
  endtask : acc
  task automatic pen(input logic [2:0] v);
    @(negedge clk);
    pen_we = 1'h1;
    pen_wdata = v;
    @(negedge clk);
    pen_we = 1'h0;
  endtask : pen
  task automatic t_reset();
    @(negedge clk);
    chk(16'({c1a, c2a}), 16'h0002);
    chk(16'(seg), 16'h000F);
    chk(16'(aok), 16'h0000);
    h = cen;
    @(negedge clk);
    chk(16'(h ^ cen), 16'h0001);
  endtask : t_reset
  task automatic t_window();
    pen(3'h3);
    chk(16'(c2a), 16'h0001);
    acc(1'h1, 24'h00EE10, 2'h3, 16'hA5C3);
    chk(16'(h), 16'h0001);
    acc(1'h1, 24'h00EE10, 2'h1, 16'h1234);
    acc(1'h0, 24'h00EE10, 2'h3, 16'h0000);
    chk(rd, 16'hA534);
    acc(1'h1, 24'h00EEFF, 2'h3, 16'h1111);
    acc(1'h1, 24'h00EF00, 2'h3, 16'h2222);
    acc(1'h0, 24'h00EEFF, 2'h3, 16'h0000);
    chk(rd, 16'h1111);
    acc(1'h0, 24'h00ED00, 2'h3, 16'h0000);
    chk({rd[14:0], h}, 16'h0000);
    pen(3'h1);
    acc(1'h1, 24'h00EE10, 2'h3, 16'h0000);
    chk(16'(h), 16'h0000);
    pen(3'h3);
    acc(1'h0, 24'h00EE10, 2'h3, 16'h0000);
    chk(rd, 16'hA534);
    glob = 1'h0;
    acc(1'h0, 24'h00EE10, 2'h3, 16'h0000);
    chk(16'({c1a, c2a, h}), 16'h0000);
    chk(16'(seg), 16'h00FF);
    glob = 1'h1;
  endtask : t_window
  task automatic t_pins();
    @(negedge clk);
    od = 4'h8;
    tx2 = 1'h0;
    #1;
    chk(16'({p_oe[3], p_out[3]}), 16'h0002);
    tx2 = 1'h1;
    rdom = 1'h1;
    #1;
    chk(16'({p_oe[3], rx1, rx2}), 16'h0000);
    rdom = 1'h0;
    #1;
    chk(16'({rx1, rx2}), 16'h0003);
  endtask : t_pins
  task automatic t_misc();
    pen(3'h7);
    // Halving off is fine here: the 25 MHz test clock is below 40 MHz
    acc(1'h1, dcg_pkg::MISC_ADDR, 2'h1, 16'h0001);
    chk(16'(cen), 16'h0001);
    @(negedge clk);
    chk(16'(cen), 16'h0001);
    chk(16'(freed), 16'h0009);
    g_oe = 4'h8;
    g_out = 4'h8;
    tx1 = 1'h0;
    #1;
    chk(16'({p_oe[3], p_out[3], p_oe[2], p_out[2]}), 16'h000E);
    chk(16'({rx1, rx2}), 16'h0000);
    chk(16'(aok), 16'h0000);
    pen(3'h3);
    acc(1'h1, dcg_pkg::MISC_ADDR, 2'h1, 16'h0002);
    pen(3'h7);
    acc(1'h0, dcg_pkg::MISC_ADDR, 2'h3, 16'h0000);
    chk(rd & 16'h0003, 16'h0001);
    pen(3'h6);
    g_oe = 4'h0;
    tx1 = 1'h1;
    tx2 = 1'h0;
    #1;
    chk(16'({freed, p_oe[3], p_out[3]}), 16'h001A);
    // Recessive transmit on an open-drain line lets go of the pin
    tx2 = 1'h1;
    @(negedge clk);
    chk(16'({p_oe[3], rx2}), 16'h0001);
  endtask : t_misc
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    {clk, rst_n, pen_we, bus_req, bus_we, rdom} = 6'h00;
    {glob, tx1, tx2} = 3'h7;
    {pen_wdata, bus_be, od, g_out, g_oe} = 17'h00000;
    bus_addr = 24'h000000;
    bus_wdata = 16'h0000;
    {err_count, n_checks, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (5) @(negedge clk);
    rst_n = 1'h1;
    t_reset();
    t_window();
    t_pins();
    t_misc();
    end_of_test();
  end
endmodule : test_dual_can_integration_glue
`default_nettype wire
